// >>> logic/bdp_pkg.sv
`default_nettype none

package bdp_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  BDP_OFS_CTRL       = 8'h00;
    localparam logic [7:0]  BDP_OFS_DUTY       = 8'h04;
    localparam logic [7:0]  BDP_OFS_PERIOD     = 8'h08;
    localparam logic [7:0]  BDP_OFS_STATUS     = 8'h0C;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int          BDP_CNT_W          = 8;
    localparam int          BDP_DUTY_W         = 10;
    localparam int          BDP_STAT_SHADOW_LSB = 8;
    localparam int          BDP_STAT_WAVE_BIT  = 24;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [6:0]  BDP_RST_CTRL       = 7'h00;
    localparam logic [9:0]  BDP_RST_DUTY       = 10'h000;
    localparam logic [7:0]  BDP_RST_PERIOD     = 8'hFF;

    // ------------------------------------------------------------------
    // Divider select codes and bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0]  BDP_DIV1           = 2'h0;
    localparam logic [1:0]  BDP_DIV2           = 2'h1;
    localparam logic [1:0]  BDP_DIV4           = 2'h2;
    localparam logic [1:0]  BDP_DIV8           = 2'h3;
    localparam logic [1:0]  BDP_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  BDP_RESP_SLVERR    = 2'h2;

    // Control register, bit 0 upward: clear, invert, enable, route,
    // divider select (2 bits), fine mode.
    typedef struct packed {
        logic       fine_mode;
        logic [1:0] clock_divider_select;
        logic       pin_route_select;
        logic       pulse_output_enable;
        logic       output_invert;
        logic       counter_clear;
    } bdp_ctrl_t;

    // Drive and enable for one output pin.
    typedef struct packed {
        logic       drive;
        logic       oe;
    } bdp_pin_t;

endpackage

`default_nettype wire

// >>> logic/bdp_pwm.sv
// Summary of operation
// - Counter clocked by CPU clock over 1/2/4/8.
// - Counter and period are eight bits, duty ten.
// - Duty writes leave the running period untouched.
// - Period end copies duty setting into shadow.
// - Invert control complements the output waveform.
// - Enabled output goes to one of two pins.
// - Clear holds counter zero, loads duty shadow.
// - Clear forces the output low at once.
// - Releasing clear drives high, starts new cycle.
// - Output low when counter reaches buffered duty.
// - Counter at period wraps to zero, output high.
// - Period writes act immediately in the compare.
// - Counter past new period overflows, one long cycle.
// - High fraction equals duty over period plus one.
// - Frequency is clock over prescale over period+1.
// - Fine mode: 1024 steps, period clock over 256.
// - Fine mode: low when base equals duty MSBs.
// - Fine mode: LSBs pick immediate or delayed rise.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module bdp_pwm
    import bdp_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Output pins
    output var  bdp_pin_t    first_output_pin,
    output var  bdp_pin_t    second_output_pin
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    bdp_ctrl_t   ctrl_reg;
    logic [9:0]  duty_setting;
    logic [7:0]  period_setting;

    wire         aw_hs    = s_axi_awvalid && s_axi_awready;
    wire         w_hs     = s_axi_wvalid && s_axi_wready;
    wire         ar_hs    = s_axi_arvalid && s_axi_arready;
    wire         do_write = !s_axi_awready && !s_axi_wready
                            && !s_axi_bvalid;
    wire         hit_ctrl = awaddr_reg == BDP_OFS_CTRL;
    wire         hit_duty = awaddr_reg == BDP_OFS_DUTY;
    wire         hit_per  = awaddr_reg == BDP_OFS_PERIOD;
    wire         hit_wr   = hit_ctrl || hit_duty || hit_per;
    wire         ctrl_wr  = do_write && hit_ctrl;

    // Byte lanes not strobed keep their old contents.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    wire [31:0] ctrl_m = merge({25'h0, ctrl_reg}, wdata_reg, wstrb_reg);
    wire [31:0] duty_m = merge({22'h0, duty_setting}, wdata_reg,
                               wstrb_reg);
    wire [31:0] per_m  = merge({24'h0, period_setting}, wdata_reg,
                               wstrb_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= BDP_RESP_OKAY;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
        end else begin
            if (aw_hs) begin
                s_axi_awready <= 1'b0;
                awaddr_reg    <= s_axi_awaddr;
            end
            if (w_hs) begin
                s_axi_wready <= 1'b0;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= hit_wr ? BDP_RESP_OKAY : BDP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg       <= BDP_RST_CTRL;
            duty_setting   <= BDP_RST_DUTY;
            period_setting <= BDP_RST_PERIOD;
        end else if (do_write) begin
            if (hit_ctrl) begin
                ctrl_reg <= bdp_ctrl_t'(ctrl_m[6:0]);
            end
            if (hit_duty) begin
                duty_setting <= duty_m[9:0];
            end
            if (hit_per) begin
                period_setting <= per_m[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0]  period_counter;
    logic [9:0]  duty_shadow;
    logic        wave_reg;

    wire  [31:0] status_w = {7'h00, wave_reg, 6'h00, duty_shadow,
                             period_counter};
    wire  [31:0] rd_val   =
        (s_axi_araddr == BDP_OFS_CTRL)   ? {25'h0, ctrl_reg}       :
        (s_axi_araddr == BDP_OFS_DUTY)   ? {22'h0, duty_setting}   :
        (s_axi_araddr == BDP_OFS_PERIOD) ? {24'h0, period_setting} :
        (s_axi_araddr == BDP_OFS_STATUS) ? status_w : 32'h0000_0000;
    wire         rd_hit   = (s_axi_araddr == BDP_OFS_CTRL)
                            || (s_axi_araddr == BDP_OFS_DUTY)
                            || (s_axi_araddr == BDP_OFS_PERIOD)
                            || (s_axi_araddr == BDP_OFS_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= BDP_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? BDP_RESP_OKAY : BDP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    logic [2:0] div_cnt_reg;

    wire        clr  = ctrl_reg.counter_clear;
    wire        fine = ctrl_reg.fine_mode;
    wire  [1:0] dsel = ctrl_reg.clock_divider_select;
    wire  [2:0] div_mask =
        (dsel == BDP_DIV1) ? 3'h0 :
        (dsel == BDP_DIV2) ? 3'h1 :
        (dsel == BDP_DIV4) ? 3'h3 : 3'h7;
    // Fine mode always runs at the full clock so its period is fixed.
    wire        tick = fine || ((div_cnt_reg & div_mask) == div_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            div_cnt_reg <= 3'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Period counter and duty shadow
    // ------------------------------------------------------------------
    logic [1:0] grp_reg;

    // Equality, not greater-or-equal, so a period lowered below the count
    // lets the counter run through overflow before the cycle ends.
    wire        end_per = fine ? (period_counter == 8'hFF)
                               : (period_counter == period_setting);
    wire        wrap    = tick && end_per;
    wire  [7:0] duty_hi = duty_shadow[9:2];
    wire        delay_w = grp_reg < duty_shadow[1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_counter <= 8'h00;
            duty_shadow    <= BDP_RST_DUTY;
            grp_reg        <= 2'h0;
        end else if (clr) begin
            period_counter <= 8'h00;
            duty_shadow    <= duty_setting;
            grp_reg        <= 2'h0;
        end else if (wrap) begin
            period_counter <= 8'h00;
            duty_shadow    <= duty_setting;
            grp_reg        <= grp_reg + 2'h1;
        end else if (tick) begin
            period_counter <= period_counter + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Waveform and pin routing
    // ------------------------------------------------------------------
    // Eight-bit mode uses the low byte of the duty setting; the high
    // fraction is duty / (period + 1).
    wire wave_8   = period_counter < duty_shadow[7:0];
    wire wave_f   = (period_counter < duty_hi)
                    && !(period_counter == 8'h00 && delay_w);
    wire wave_nxt = clr ? 1'b0 : (fine ? wave_f : wave_8);
    wire pin_lvl  = wave_nxt ^ ctrl_reg.output_invert;
    wire route_a  = ctrl_reg.pulse_output_enable
                    && !ctrl_reg.pin_route_select;
    wire route_b  = ctrl_reg.pulse_output_enable
                    && ctrl_reg.pin_route_select;

    // Pins are fed from the next waveform value so that they line up with
    // the internal waveform register instead of lagging it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_reg          <= 1'b0;
            first_output_pin  <= '0;
            second_output_pin <= '0;
        end else begin
            wave_reg          <= wave_nxt;
            first_output_pin  <= '{drive: route_a && pin_lvl, oe: route_a};
            second_output_pin <= '{drive: route_b && pin_lvl, oe: route_b};
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire inv_w = ctrl_reg.output_invert;

    sequence div4_gap_s;
        (!tick) [*3] ##1 tick;
    endsequence

    clr_low_a: assert property (clr |=> !wave_reg)
        else $error("Output not low under counter clear.");
    clr_hold_a: assert property (clr
        |=> period_counter == 8'h00 && duty_shadow == $past(duty_setting))
        else $error("Counter clear did not hold and load.");
    // A control write in the tick cycle itself is seen only as sampled,
    // so it is excluded here as well as by the disable condition.
    div_four_a: assert property (disable iff (!aresetn || ctrl_wr)
        tick && !fine && !clr && !ctrl_wr && dsel == 2'b10
        |=> div4_gap_s)
        else $error("Divide-by-four tick spacing wrong.");
    duty_hold_a: assert property (!clr && !wrap
        |=> $stable(duty_shadow))
        else $error("Duty shadow changed mid period.");
    duty_load_a: assert property (!clr && wrap
        |=> duty_shadow == $past(duty_setting))
        else $error("Duty shadow not loaded at period end.");
    period_wrap_a: assert property (!clr && !fine && wrap
        |=> period_counter == 8'h00)
        else $error("Counter did not wrap at period.");
    long_cycle_a: assert property (!clr && !fine && tick
        && period_counter > period_setting && period_counter != 8'hFF
        |=> period_counter == 8'($past(period_counter) + 8'h01))
        else $error("Counter past period did not count on.");
    cmp_low_a: assert property (!clr && !fine
        && period_counter >= duty_shadow[7:0] |=> !wave_reg)
        else $error("Output high at or past duty.");
    release_a: assert property ($past(clr) && !clr && !fine
        && duty_shadow[7:0] != 8'h00 |=> wave_reg)
        else $error("Output not high after clear release.");
    pin_route_a: assert property ($past(route_a)
        |-> first_output_pin.oe && !second_output_pin.oe
        && first_output_pin.drive == (wave_reg ^ $past(inv_w)))
        else $error("First pin not driven with routed waveform.");
    fine_fall_a: assert property (fine && !clr
        && period_counter == duty_hi ##1 !clr |-> !wave_reg)
        else $error("Fine mode output not low at match.");
    fine_rise_a: assert property (fine && !clr
        && period_counter == 8'h00 && duty_hi != 8'h00
        |=> wave_reg != $past(delay_w))
        else $error("Fine mode rise delay wrong.");
    fine_roll_a: assert property (fine && !clr
        && period_counter == 8'hFF |=> period_counter == 8'h00)
        else $error("Fine mode base counter not 256 long.");

endmodule

`default_nettype wire

// >>> verification/bdp_pwm_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    n_errors++; $display("mismatch at %0t: got %0h expected %0h", \
    $time, (got), (exp)); end end

module buffered_duty_pwm_tb_top
    import bdp_pkg::*;
;
    // ------------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------------
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_awvalid;
    logic        s_axi_wvalid;
    logic        s_axi_bready;
    logic        s_axi_arvalid;
    logic        s_axi_rready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awready;
    logic        s_axi_wready;
    logic        s_axi_bvalid;
    logic        s_axi_arready;
    logic        s_axi_rvalid;
    logic [1:0]  s_axi_bresp;
    logic [1:0]  s_axi_rresp;
    logic [31:0] s_axi_rdata;
    bdp_pin_t    first_output_pin;
    bdp_pin_t    second_output_pin;
    logic        wv;
    logic [31:0] rd;
    logic [1:0]  rr;
    int          n_errors;
    int          num_checks;
    int          cycles;
    int          hi;
    int          tot;

    // A disabled pin drives low, so the OR shows whichever pin is routed.
    assign wv = first_output_pin.drive | second_output_pin.drive;

    bdp_pwm i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .first_output_pin,
        .second_output_pin);

    // ------------------------------------------------------------------
    // Bus and measurement tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [31:0] cw(logic clr, logic inv, logic en,
                                       logic rt, logic [1:0] dv, logic fn);
        bdp_ctrl_t c;
        c = {fn, dv, rt, en, inv, clr};
        return {25'h000_0000, c};
    endfunction

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Counts high samples and total samples from one rise to the next.
    task automatic measure();
        logic p;
        p = wv;
        tot = 0;
        @(posedge aclk);
        while (!(p === 1'b0 && wv === 1'b1)) begin
            p = wv;
            tot++;
            @(posedge aclk);
        end
        hi = 0;
        tot = 0;
        do begin
            if (wv === 1'b1) hi++;
            tot++;
            p = wv;
            @(posedge aclk);
        end while (!(p === 1'b0 && wv === 1'b1));
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and test sequence
    // ------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        n_errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (10) @(posedge aclk);
        `CHK(first_output_pin, 2'b00)
        aresetn <= 1'b1;
        axr(BDP_OFS_CTRL);
        `CHK(rd, 32'h0000_0000)
        axr(BDP_OFS_DUTY);
        `CHK(rd, 32'h0000_0000)
        axr(BDP_OFS_PERIOD);
        `CHK(rd, 32'h0000_00FF)
        axr(8'h10);
        `CHK(rr, BDP_RESP_SLVERR)
        axw(BDP_OFS_STATUS, 32'h0000_0001, BDP_RESP_SLVERR);
        axw(BDP_OFS_PERIOD, 32'h0000_0009, BDP_RESP_OKAY);
        axw(BDP_OFS_DUTY, 32'h0000_0004, BDP_RESP_OKAY);
        for (int d = 0; d < 4; d++) begin
            axw(BDP_OFS_CTRL, cw(0, 0, 1, 0, 2'(d), 0), BDP_RESP_OKAY);
            measure();
            measure();
            `CHK(hi, 4 << d)
            `CHK(tot, 10 << d)
        end
        axw(BDP_OFS_CTRL, cw(0, 1, 1, 0, BDP_DIV1, 0), BDP_RESP_OKAY);
        measure();
        `CHK(hi, 6)
        axw(BDP_OFS_CTRL, cw(0, 0, 1, 1, BDP_DIV1, 0), BDP_RESP_OKAY);
        measure();
        `CHK(first_output_pin.oe, 1'b0)
        `CHK(second_output_pin.oe, 1'b1)
        `CHK(hi, 4)
        axw(BDP_OFS_CTRL, cw(0, 0, 0, 0, BDP_DIV1, 0), BDP_RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK({first_output_pin, second_output_pin}, 4'h0)
        axw(BDP_OFS_CTRL, cw(1, 0, 1, 0, BDP_DIV1, 0), BDP_RESP_OKAY);
        axw(BDP_OFS_DUTY, 32'h0000_0007, BDP_RESP_OKAY);
        repeat (20) @(posedge aclk);
        `CHK(wv, 1'b0)
        axr(BDP_OFS_STATUS);
        `CHK(rd[7:0], 8'h00)
        `CHK(rd[BDP_STAT_WAVE_BIT], 1'b0)
        `CHK(rd[BDP_STAT_SHADOW_LSB +: BDP_DUTY_W], 10'h007)
        axw(BDP_OFS_CTRL, cw(0, 0, 1, 0, BDP_DIV1, 0), BDP_RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(wv, 1'b1)
        measure();
        `CHK(hi, 7)
        axw(BDP_OFS_PERIOD, 32'h0000_00FF, BDP_RESP_OKAY);
        axw(BDP_OFS_CTRL, cw(0, 0, 1, 0, BDP_DIV8, 0), BDP_RESP_OKAY);
        measure();
        axw(BDP_OFS_DUTY, 32'h0000_00C8, BDP_RESP_OKAY);
        axr(BDP_OFS_STATUS);
        `CHK(rd[BDP_STAT_SHADOW_LSB +: BDP_DUTY_W], 10'h007)
        `CHK(rd[BDP_STAT_WAVE_BIT], 1'b1)
        repeat (2100) @(posedge aclk);
        axr(BDP_OFS_STATUS);
        `CHK(rd[BDP_STAT_SHADOW_LSB +: BDP_DUTY_W], 10'h0C8)
        axw(BDP_OFS_DUTY, 32'h0000_0007, BDP_RESP_OKAY);
        axw(BDP_OFS_CTRL, cw(0, 0, 1, 0, BDP_DIV1, 0), BDP_RESP_OKAY);
        measure();
        repeat (100) @(posedge aclk);
        axw(BDP_OFS_PERIOD, 32'h0000_0009, BDP_RESP_OKAY);
        axr(BDP_OFS_STATUS);
        `CHK(rd[7:0] > 8'h09, 1'b1)
        // The counter has to run through overflow before the next rise.
        hi = 0;
        while (wv !== 1'b1) begin
            @(posedge aclk);
            hi++;
        end
        `CHK(hi, 256 - rd[7:0])
        measure();
        measure();
        `CHK(tot, 10)
        // Any 1024-clock window holds four base periods, one of each group.
        for (int l = 0; l < 4; l++) begin
            axw(BDP_OFS_DUTY, 32'h0000_0100 + l, BDP_RESP_OKAY);
            axw(BDP_OFS_CTRL, cw(0, 0, 1, 0, BDP_DIV1, 1), BDP_RESP_OKAY);
            repeat (300) @(posedge aclk);
            hi = 0;
            repeat (1024) begin
                @(posedge aclk);
                if (wv === 1'b1) hi++;
            end
            `CHK(hi, 256 - l)
        end
        conclude();
    end
endmodule

`default_nettype wire
